// ### rtl/jip_pkg.sv
package jip_pkg;

  // ----------------------------------------
  // test port widths and instruction codes
  // ----------------------------------------
  localparam int IR_LEN = 10;
  localparam int DR_LEN = 32;
  localparam logic [9:0] IR_CAPTURE = 10'h001;
  localparam logic [9:0] IR_IDCODE = 10'h006;
  localparam logic [9:0] IR_BYPASS = 10'h3ff;
  localparam logic [9:0] IR_ENTER = 10'h2cc;
  localparam logic [9:0] IR_EXIT = 10'h201;
  localparam logic [9:0] IR_CLAMP = 10'h2cd;
  localparam logic [9:0] IR_ADDR = 10'h203;
  localparam logic [9:0] IR_DATA = 10'h2e0;
  localparam logic [9:0] IR_ERASE = 10'h2f2;
  localparam logic [9:0] IR_PROG = 10'h2f4;
  localparam logic [9:0] IR_VERIFY = 10'h205;
  localparam logic [9:0] IR_RELOAD = 10'h279;

  // ----------------------------------------
  // pulse timing at the pclk rate
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned ERASE_MS = 500;
  localparam int unsigned PROG_US = 75;
  localparam int unsigned READ_NS = 200;
  localparam int unsigned RELOAD_US = 100;
  localparam int unsigned ERASE_CYC = ERASE_MS * CLK_KHZ;
  localparam int unsigned PROG_CYC = (PROG_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned READ_CYC = (READ_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned RELOAD_CYC = (RELOAD_US * CLK_KHZ + 999) / 1000;

  // ----------------------------------------
  // flash address layout and erased value
  // ----------------------------------------
  localparam int RGN_LSB = 14;
  localparam logic [1:0] RGN_CFG = 2'h0;
  localparam logic [1:0] RGN_USR = 2'h1;
  localparam logic [1:0] RGN_SPC = 2'h2;
  localparam int SPC_DONE_BIT = 0;
  localparam int SPC_SEC_BIT = 1;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CLAMP = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam int CTRL_RT_BIT = 0;
  localparam logic CTRL_RST = 1'b0;

  // per-pin clamp choices, two bits each
  localparam logic [1:0] CLP_FLOAT = 2'h0;
  localparam logic [1:0] CLP_HIGH = 2'h1;
  localparam logic [1:0] CLP_LOW = 2'h2;
  localparam logic [1:0] CLP_SAMPLE = 2'h3;

  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_PROG = 2'b01,
    OP_READ = 2'b10
  } jip_op_type;

  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000,
    TAP_IDLE = 4'b0001,
    TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011,
    TAP_SH_DR = 4'b0100,
    TAP_EX1_DR = 4'b0101,
    TAP_PA_DR = 4'b0110,
    TAP_EX2_DR = 4'b0111,
    TAP_UP_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001,
    TAP_CAP_IR = 4'b1010,
    TAP_SH_IR = 4'b1011,
    TAP_EX1_IR = 4'b1100,
    TAP_PA_IR = 4'b1101,
    TAP_EX2_IR = 4'b1110,
    TAP_UP_IR = 4'b1111
  } jip_tap_type;

endpackage

// ### rtl/jip_tap.sv
`timescale 1ns/1ps
module jip_tap
  import jip_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sampled port
  input wire logic tck_rise,
  input wire logic tms,
  // state
  output jip_tap_type state
);

  jip_tap_type state_d;

  // ----------------------------------------
  // test port state walk
  // ----------------------------------------
  always_comb
  begin
    case (state)
      TAP_RESET: state_d = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_d = tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR: state_d = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: state_d = tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_d = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_d = tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR: state_d = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: state_d = tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      default: state_d = TAP_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= TAP_RESET;
    else if (tck_rise)
      state <= state_d;
  end

endmodule // jip_tap

// ### rtl/jip_isp_ctrl.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module jip_isp_ctrl
  import jip_pkg::*;
#(
  parameter int N_IO = 8,
  parameter int CFG_WORDS = 64,
  parameter int USR_WORDS = 16,
  parameter int USR_SECTORS = 2,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter logic [31:0] ID_CODE = 32'h0a5c_3001 // arbitrary value
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // running design side of the pins
  input wire logic [N_IO-1:0] usr_out,
  input wire logic [N_IO-1:0] usr_oe,
  // pins
  output logic [N_IO-1:0] io_out,
  output logic [N_IO-1:0] io_oe,
  output logic [N_IO-1:0] io_pullup
);

  localparam int CFG_AW = $clog2(CFG_WORDS);
  localparam int USR_AW = $clog2(USR_WORDS);
  localparam int SEC_W = USR_WORDS / USR_SECTORS;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] tck_s;
  logic [1:0] tms_s;
  logic [1:0] tdi_s;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tck_s <= 3'h0;
      tms_s <= 2'h0;
      tdi_s <= 2'h0;
    end
    else
    begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
    end
  end
  wire tck_rise = tck_s[1] & ~tck_s[2];
  wire tck_fall = ~tck_s[1] & tck_s[2];

  jip_tap_type tap_st;
  jip_tap_type tap_prev_q;
  jip_tap u_tap (
    .pclk(pclk),
    .presetn(presetn),
    .tck_rise(tck_rise),
    .tms(tms_s[1]),
    .state(tap_st)
  );

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  logic [IR_LEN-1:0] ir_sr_q, ir_q;
  logic [DR_LEN-1:0] dr_q, addr_q, data_q, read_q;
  logic byp_q, session_q, clamp_arm_q, clamp_q, reload_arm_q, reload_q;
  logic done_q, sec_q, rt_q, busy_q, tdo_q, tdo_oe_q;
  logic [15:0] reload_cnt_q;
  logic [23:0] timer_q, elapsed_q;
  jip_op_type op_q;
  logic [2*N_IO-1:0] clamp_cfg_q;
  logic [N_IO-1:0] clamp_lvl_q, clamp_en_q;
  logic [31:0] cfg_mem [CFG_WORDS];
  logic [31:0] usr_mem [USR_WORDS];

  wire cap_dr = tck_rise && tap_st == TAP_CAP_DR;
  wire sh_dr = tck_rise && tap_st == TAP_SH_DR;
  wire up_dr = tck_rise && tap_st == TAP_UP_DR;
  wire cap_ir = tck_rise && tap_st == TAP_CAP_IR;
  wire sh_ir = tck_rise && tap_st == TAP_SH_IR;
  wire up_ir = tck_rise && tap_st == TAP_UP_IR;
  wire long_dr = ir_q == IR_IDCODE || ir_q == IR_ADDR || ir_q == IR_DATA
                 || ir_q == IR_VERIFY;
  wire [1:0] region = addr_q[RGN_LSB+1:RGN_LSB];
  wire [CFG_AW-1:0] cidx = addr_q[CFG_AW-1:0];
  wire [USR_AW-1:0] uidx = addr_q[USR_AW-1:0];
  wire pulse_ir = ir_q == IR_ERASE || ir_q == IR_PROG || ir_q == IR_VERIFY;
  wire enter_idle = tap_st == TAP_IDLE && tap_prev_q != TAP_IDLE;
  wire op_start = enter_idle && session_q && pulse_ir;
  wire op_fire = busy_q && tap_st == TAP_IDLE && timer_q == 24'h1;
  wire fire_erase = op_fire && op_q == OP_ERASE;
  wire fire_prog = op_fire && op_q == OP_PROG;
  wire fire_read = op_fire && op_q == OP_READ;
  // only flash is ever returned; the configuration sram has no read path
  wire [31:0] read_word = region == RGN_CFG ? (sec_q ? 32'h0 : cfg_mem[cidx])
                        : region == RGN_USR ? usr_mem[uidx]
                        : {30'h0, sec_q, done_q};
  wire [23:0] op_len = ir_q == IR_ERASE ? 24'(ERASE_CYCLES)
                     : ir_q == IR_PROG ? 24'(PROG_CYC) : 24'(READ_CYC);

  // ----------------------------------------
  // instruction and data registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_sr_q <= IR_CAPTURE;
      ir_q <= IR_IDCODE;
    end
    else if (tck_rise && tap_st == TAP_RESET)
      ir_q <= IR_IDCODE;
    else if (cap_ir)
      ir_sr_q <= IR_CAPTURE;
    else if (sh_ir)
      ir_sr_q <= {tdi_s[1], ir_sr_q[IR_LEN-1:1]};
    else if (up_ir)
      ir_q <= ir_sr_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dr_q <= 32'h0;
      byp_q <= 1'b0;
    end
    else if (cap_dr)
    begin
      dr_q <= ir_q == IR_IDCODE ? ID_CODE : ir_q == IR_VERIFY ? read_q : dr_q;
      byp_q <= 1'b0;
    end
    else if (sh_dr)
    begin
      dr_q <= {tdi_s[1], dr_q[DR_LEN-1:1]};
      byp_q <= tdi_s[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q <= 32'h0;
      data_q <= ERASED_WORD;
    end
    else if (up_dr && ir_q == IR_ADDR)
      addr_q <= dr_q;
    else if (up_dr && ir_q == IR_DATA)
      data_q <= dr_q;
  end

  // tdo changes on the falling test clock so the programmer samples it settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_q <= tap_st == TAP_SH_IR ? ir_sr_q[0] : long_dr ? dr_q[0] : byp_q;
      tdo_oe_q <= tap_st == TAP_SH_IR || tap_st == TAP_SH_DR;
    end
  end

  // ----------------------------------------
  // session, clamp and reload control
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      session_q <= 1'b0;
      clamp_arm_q <= 1'b0;
      clamp_q <= 1'b0;
      reload_arm_q <= 1'b0;
    end
    else if (up_ir && ir_sr_q == IR_ENTER)
    begin
      session_q <= 1'b1;
      clamp_q <= clamp_arm_q;
    end
    else if (up_ir && ir_sr_q == IR_CLAMP)
      clamp_arm_q <= 1'b1;
    else if (up_ir && ir_sr_q == IR_RELOAD && session_q)
      reload_arm_q <= 1'b1;
    else if (up_ir && ir_sr_q == IR_EXIT)
    begin
      session_q <= 1'b0;
      clamp_q <= 1'b0;
      clamp_arm_q <= 1'b0;
      reload_arm_q <= 1'b0;
    end
  end

  // pin levels are caught when clamp is loaded, before the session starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clamp_lvl_q <= '0;
      clamp_en_q <= '0;
    end
    else if (up_ir && ir_sr_q == IR_CLAMP)
    begin
      clamp_lvl_q <= usr_out;
      clamp_en_q <= usr_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reload_q <= 1'b0;
      reload_cnt_q <= 16'h0;
    end
    else if (up_ir && ir_sr_q == IR_EXIT && reload_arm_q)
    begin
      reload_q <= 1'b1;
      reload_cnt_q <= 16'(RELOAD_CYC);
    end
    else if (reload_q)
    begin
      reload_cnt_q <= reload_cnt_q - 16'h1;
      reload_q <= reload_cnt_q != 16'h1;
    end
  end

  // ----------------------------------------
  // pulse timer, counted in pclk cycles
  // ----------------------------------------
  // leaving idle early aborts the pulse; the cells are left untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      timer_q <= 24'h0;
      elapsed_q <= 24'h0;
      op_q <= OP_READ;
      tap_prev_q <= TAP_RESET;
    end
    else
    begin
      tap_prev_q <= tap_st;
      if (op_start)
      begin
        busy_q <= 1'b1;
        timer_q <= op_len;
        elapsed_q <= 24'h0;
        op_q <= ir_q == IR_ERASE ? OP_ERASE : ir_q == IR_PROG ? OP_PROG : OP_READ;
      end
      else if (busy_q)
      begin
        busy_q <= tap_st == TAP_IDLE && timer_q != 24'h1;
        timer_q <= timer_q - 24'h1;
        elapsed_q <= elapsed_q + 24'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_q <= 32'h0;
    else if (fire_read)
      read_q <= read_word;
  end

  // ----------------------------------------
  // flash arrays and flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
      sec_q <= 1'b0;
    end
    else if (fire_erase && region == RGN_CFG)
    begin
      done_q <= 1'b0;
      sec_q <= 1'b0;
    end
    else if (fire_prog && region == RGN_SPC)
    begin
      done_q <= done_q | data_q[SPC_DONE_BIT];
      sec_q <= sec_q | data_q[SPC_SEC_BIT];
    end
  end

  generate
    for (genvar w = 0; w < CFG_WORDS; w++)
    begin : g_cfg
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cfg_mem[w] <= ERASED_WORD;
        else if (fire_erase && region == RGN_CFG)
          cfg_mem[w] <= ERASED_WORD;
        else if (fire_prog && region == RGN_CFG && cidx == CFG_AW'(w))
          cfg_mem[w] <= data_q;
      end
    end
    for (genvar w = 0; w < USR_WORDS; w++)
    begin : g_usr
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          usr_mem[w] <= ERASED_WORD;
        else if (fire_erase && region == RGN_USR && int'(uidx) / SEC_W == w / SEC_W)
          usr_mem[w] <= ERASED_WORD;
        else if (fire_prog && region == RGN_USR && uidx == USR_AW'(w))
          usr_mem[w] <= data_q;
      end
    end
  endgenerate

  // ----------------------------------------
  // pin behaviour
  // ----------------------------------------
  wire float_all = reload_q || (!session_q && !done_q)
                   || (session_q && !rt_q && !clamp_q);
  wire user_mode = !float_all && (!session_q || rt_q);
  logic [N_IO-1:0] pin_out_d, pin_oe_d, pin_pu_d;
  generate
    for (genvar i = 0; i < N_IO; i++)
    begin : g_pin
      wire [1:0] sel = clamp_cfg_q[2*i+1:2*i];
      wire c_oe = sel == CLP_HIGH || sel == CLP_LOW
                  || (sel == CLP_SAMPLE && clamp_en_q[i]);
      wire c_out = sel == CLP_HIGH || (sel == CLP_SAMPLE && clamp_lvl_q[i]);
      assign pin_out_d[i] = float_all ? 1'b0 : user_mode ? usr_out[i] : c_out;
      assign pin_oe_d[i] = float_all ? 1'b0 : user_mode ? usr_oe[i] : c_oe;
      assign pin_pu_d[i] = float_all || (!user_mode && !c_oe);
    end
  endgenerate

  // all pins switch on the same pclk edge from flops, so no pin glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_out <= '0;
      io_oe <= '0;
      io_pullup <= '1;
    end
    else
    begin
      io_out <= pin_out_d;
      io_oe <= pin_oe_d;
      io_pullup <= pin_pu_d;
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  wire setup = psel && !penable;
  wire hit = paddr == A_CTRL || paddr == A_CLAMP || paddr == A_STATUS;
  wire wr_en = psel && penable && pready && pwrite && !pslverr;
  wire [31:0] status_w = {20'h0, 4'(tap_st), 1'b0, rt_q, reload_q, busy_q,
                          clamp_q, session_q, sec_q, done_q};
  wire [31:0] rd_mux = paddr == A_CTRL ? {31'h0, rt_q}
                     : paddr == A_CLAMP ? 32'(clamp_cfg_q)
                     : paddr == A_STATUS ? status_w : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !hit;
      prdata <= setup && !pwrite ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rt_q <= CTRL_RST;
      clamp_cfg_q <= '0;
    end
    else if (wr_en && paddr == A_CTRL)
      rt_q <= pwdata[CTRL_RT_BIT];
    else if (wr_en && paddr == A_CLAMP)
      clamp_cfg_q <= pwdata[2*N_IO-1:0];
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  done_float_a: assert property (!done_q && !session_q |=> io_oe == '0)
    else $error("pins drive while completion flag unprogrammed");
  sess_float_a: assert property (session_q && !rt_q && !clamp_q |=> io_oe == '0 && io_pullup == '1)
    else $error("pins not floating with pull-up in session");
  reload_float_a: assert property (reload_q |=> io_oe == '0 && io_pullup == '1)
    else $error("pins not floating during reload");
  rt_user_a: assert property (session_q && rt_q && !reload_q |=> io_oe == $past(usr_oe))
    else $error("real-time mode disturbed the running design");
  sec_block_a: assert property (fire_read && sec_q && region == RGN_CFG |=> read_q == 32'h0)
    else $error("configuration data leaked while secured");
  prog_len_a: assert property (fire_prog |-> elapsed_q == 24'(PROG_CYC) - 24'h1)
    else $error("program pulse length wrong");
  erase_len_a: assert property (fire_erase |-> elapsed_q == 24'(ERASE_CYCLES) - 24'h1)
    else $error("erase pulse length wrong");
  erase_clear_a: assert property (fire_erase && region == RGN_CFG |=> !sec_q && !done_q)
    else $error("erase left security or completion set");
  id_capture_a: assert property (cap_dr && ir_q == IR_IDCODE |=> dr_q == ID_CODE)
    else $error("identity code not captured");
  user_iso_a: assert property (fire_prog && region == RGN_USR |=> $stable(cfg_mem[0]) && $stable(sec_q))
    else $error("user flash write disturbed configuration flash");

endmodule // jip_isp_ctrl

// ### tb/jip_prog_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// external test port programmer
// ----------------------------------------
module jip_prog_model (
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tck parked low between frames
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #160 tck = 1'b1;
    // a released tdo reads as its pull-up
    q = tdo_oe ? tdo : 1'b1;
    #160 tck = 1'b0;
  endtask
  // five ones reach reset, then idle
  task automatic treset();
    logic q;
    // half a system clock of slack each side keeps pin edges off the sampling edge
    #20;
    for (int i = 0; i < 6; i++)
      cyc(i < 5, 1'b0, q);
    #20;
  endtask
  // idle to shift, lsb first, back to idle
  task automatic shift(input logic ir, input int n, input logic [31:0] d,
    output logic [31:0] q);
    logic b;
    #20;
    q = '0;
    cyc(1'b1, 1'b0, b);
    if (ir)
      cyc(1'b1, 1'b0, b);
    cyc(1'b0, 1'b0, b);
    cyc(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      cyc(i == n - 1, d[i], b);
      q[i] = b;
    end
    // tdi no longer holds the last bit
    cyc(1'b1, ~d[n-1], b);
    cyc(1'b0, d[n-1], b);
    #20;
  endtask
endmodule // jip_prog_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb
  import jip_pkg::*;
();
  localparam int unsigned ERC = 200;
  localparam logic [31:0] IDC = 32'h0a5c_3001; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [7:0] paddr, usr_out, usr_oe, io_out, io_oe, io_pullup;
  logic [31:0] pwdata, prdata, rv;
  int err_count = 0;
  int num_checks = 0;
  jip_isp_ctrl #(.ERASE_CYCLES(ERC), .ID_CODE(IDC)) u_jip_isp_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .usr_out(usr_out), .usr_oe(usr_oe),
    .io_out(io_out), .io_oe(io_oe), .io_pullup(io_pullup));
  jip_prog_model u_jip_prog_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e);
    apb(1'b0, A_STATUS, 32'h0);
    chk("status", rv & 32'h7f, e);
  endtask
  task automatic ir(input logic [9:0] c);
    u_jip_prog_model.shift(1'b1, 10, {22'h0, c}, rv);
  endtask
  task automatic dr(input logic [9:0] c, input logic [31:0] d);
    ir(c);
    u_jip_prog_model.shift(1'b0, 32, d, rv);
  endtask
  task automatic prog(input logic [31:0] a, input logic [31:0] d);
    dr(IR_ADDR, a);
    dr(IR_DATA, d);
    ir(IR_PROG);
    #(PROG_CYC * 40 + 400);
  endtask
  task automatic erase(input logic [31:0] a);
    dr(IR_ADDR, a);
    ir(IR_ERASE);
    #(ERC * 40 + 400);
  endtask
  task automatic vfy(input string nm, input logic [31:0] a, input logic [31:0] e);
    dr(IR_ADDR, a);
    ir(IR_VERIFY);
    #400;
    u_jip_prog_model.shift(1'b0, 32, 32'h0, rv);
    chk(nm, rv, e);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, the tests need about 1.1 ms
  initial
  begin
    #3000000;
    err_count++;
    end_sim();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    usr_out = 8'h0a;
    usr_oe = 8'h0f;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe", {24'h0, io_oe}, 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl", rv, 32'h0);
    apb(1'b1, 8'h0c, 32'h1);
    chk("slverr", {31'h0, ev}, 32'h1);
    apb(1'b1, A_CLAMP, 32'hc9);
    apb(1'b0, A_CLAMP, 32'h0);
    chk("clamp", rv, 32'hc9);
    $display("test registers done");
    u_jip_prog_model.treset();
    u_jip_prog_model.shift(1'b1, 10, {22'h0, IR_ENTER}, rv);
    chk("ircap", rv, {22'h0, IR_CAPTURE});
    chk("oe", {24'h0, io_oe}, 32'h0);
    chk("pu", {24'h0, io_pullup}, 32'hff);
    dr(IR_IDCODE, 32'h0);
    chk("id", rv, IDC);
    chk("toe", {31'h0, tdo_oe}, 32'h0);
    dr(IR_BYPASS, 32'h8765_4321);
    chk("byp", rv, 32'h0eca_8642);
    erase(32'h0);
    erase(32'h4000);
    prog(32'h5, 32'h1234_5678);
    prog(32'h4003, 32'hcafe_0001);
    vfy("cfg", 32'h5, 32'h1234_5678);
    vfy("usr", 32'h4003, 32'hcafe_0001);
    prog(32'h8000, 32'h2);
    vfy("sec", 32'h5, 32'h0);
    vfy("usr", 32'h4003, 32'hcafe_0001);
    prog(32'h8000, 32'h1);
    st(32'h07);
    ir(IR_EXIT);
    chk("oe", {24'h0, io_oe}, {24'h0, usr_oe});
    chk("out", {24'h0, io_out & io_oe}, {24'h0, usr_out & usr_oe});
    $display("test program done");
    ir(IR_CLAMP);
    ir(IR_ENTER);
    chk("coe", {24'h0, io_oe}, 32'h0b);
    chk("cout", {24'h0, io_out & io_oe}, 32'h09);
    erase(32'h0);
    st(32'h0c);
    vfy("ers", 32'h5, 32'hffff_ffff);
    prog(32'h8000, 32'h1);
    ir(IR_EXIT);
    $display("test clamp done");
    apb(1'b1, A_CTRL, 32'h1);
    ir(IR_ENTER);
    chk("rt", {24'h0, io_oe}, {24'h0, usr_oe});
    st(32'h45);
    ir(IR_RELOAD);
    ir(IR_EXIT);
    chk("rld", {24'h0, io_oe}, 32'h0);
    chk("rpu", {24'h0, io_pullup}, 32'hff);
    #(RELOAD_CYC * 40 + 400);
    chk("after", {24'h0, io_oe}, {24'h0, usr_oe});
    // completion flag set, so only the session itself can float the pins here
    apb(1'b1, A_CTRL, 32'h0);
    ir(IR_ENTER);
    chk("doe", {24'h0, io_oe}, 32'h0);
    chk("dpu", {24'h0, io_pullup}, 32'hff);
    erase(32'h4000);
    vfy("uers", 32'h4003, 32'hffff_ffff);
    ir(IR_EXIT);
    chk("xoe", {24'h0, io_oe}, {24'h0, usr_oe});
    $display("test reload done");
    end_sim();
  end
endmodule // tb
